// ==== design/exec_pkg.sv ====
package exec_pkg;

	localparam int          DATA_W      = 8;
	localparam int          ADDR_W      = 16;
	localparam int          REG_COUNT   = 32;
	localparam int          REG_IDX_W   = 5;
	localparam int          DISP_W      = 6;
	localparam int          IO_ADDR_W   = 6;
	localparam int          IO_BIT_ADDR = 5;
	localparam int          BIT_SEL_W   = 3;

	// Low halves of the three pointer pairs
	localparam logic [4:0]  PTR_X_LO    = 5'h1a;
	localparam logic [4:0]  PTR_Y_LO    = 5'h1c;
	localparam logic [4:0]  PTR_Z_LO    = 5'h1e;

	localparam logic [15:0] STEP_ONE    = 16'h0001;
	localparam logic [7:0]  BIT_ONE     = 8'h01;
	localparam logic [15:0] SP_RESET    = 16'h00ff;

	// Status flag positions
	localparam int          FLAG_C      = 0;
	localparam int          FLAG_Z      = 1;
	localparam int          FLAG_N      = 2;
	localparam int          FLAG_V      = 3;

	localparam int          ROT_CYCLES  = 1;
	localparam int          MEM_CYCLES  = 2;

	typedef enum logic [3:0] {
		op_indirect_store       = 4'h0,
		op_indirect_store_inc   = 4'h1,
		op_indirect_store_dec   = 4'h2,
		op_displaced_store      = 4'h3,
		op_push                 = 4'h4,
		op_pop                  = 4'h5,
		op_io_bit_set           = 4'h6,
		op_io_bit_clear         = 4'h7,
		op_rotate_up_via_carry  = 4'h8
	} op_t;

	typedef enum logic [1:0] {
		ptr_x = 2'h0,
		ptr_y = 2'h1,
		ptr_z = 2'h2
	} ptr_t;

	typedef enum logic [1:0] {
		s_idle   = 2'h0,
		s_second = 2'h1
	} state_t;

endpackage

// ==== design/rot_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface rot_if;
	logic [7:0] operand;
	logic       carry_in;
	logic [7:0] result;
	logic       carry_out;
	logic       zero;
	logic       negative;
	logic       overflow;

	modport client (output operand, output carry_in,
		input result, input carry_out, input zero, input negative, input overflow);
	modport unit (input operand, input carry_in,
		output result, output carry_out, output zero, output negative, output overflow);
endinterface
`default_nettype wire

// ==== design/rotate_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module rotate_unit (
	rot_if.unit rp
);
	assign rp.result    = {rp.operand[6:0], rp.carry_in};
	assign rp.carry_out = rp.operand[7];
	assign rp.zero      = (rp.result == 8'h00);
	assign rp.negative  = rp.result[7];
	// Overflow follows sign change: N xor C after the shift
	assign rp.overflow  = rp.result[7] ^ rp.operand[7];
endmodule
`default_nettype wire

// ==== design/store_stack_bit_shift_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Post-increment store writes source to pointer address, then bumps pointer; two cycles.
// - Pre-decrement store lowers pointer first, writes to new address; two cycles, no flags.
// - Displacement store writes to pointer plus offset, pointer kept; two cycles.
// - Push writes named register onto stack in data memory; two cycles, no flags.
// - Pop loads named register from stack top; two cycles, no flags.
// - I/O bit set forces one bit to one, keeps others; two cycles.
// - I/O bit clear forces one bit to zero, keeps others; two cycles.
// - Rotate left through carry updates Z, C, N, V in one cycle.
module store_stack_bit_shift_exec #(
	parameter logic [15:0] SP_INIT = exec_pkg::SP_RESET
) (
	// Clock and reset
	input  wire logic          mclk,
	input  wire logic          rst_b,
	// Instruction command
	input  wire logic          start,
	input  wire exec_pkg::op_t op,
	input  wire exec_pkg::ptr_t ptr_sel,
	input  wire logic [4:0]    source_working_reg,
	input  wire logic [4:0]    dest_reg,
	input  wire logic [5:0]    disp,
	input  wire logic [4:0]    io_bit_addr,
	input  wire logic [2:0]    bit_sel,
	output logic               ready,
	output logic               done,
	// Working register preload and view
	input  wire logic          rf_we,
	input  wire logic [4:0]    rf_addr,
	input  wire logic [7:0]    rf_wdata,
	output logic [7:0]         rf_rdata,
	output logic [15:0]        sp,
	output logic [7:0]         sreg,
	// Data memory
	output logic [15:0]        dmem_addr,
	output logic [7:0]         dmem_wdata,
	output logic               dmem_we,
	output logic               dmem_re,
	input  wire logic [7:0]    dmem_rdata,
	// I/O register space
	output logic [5:0]         io_addr,
	output logic [7:0]         io_wdata,
	output logic               io_we,
	output logic               io_re,
	input  wire logic [7:0]    io_rdata
);
	// Whole core state, registered as one word
	typedef struct packed {
		exec_pkg::state_t state;
		logic [31:0][7:0] regs;
		logic [15:0]      sp;
		logic [7:0]       sreg;
		logic [15:0]      dmem_addr;
		logic [7:0]       dmem_wdata;
		logic             dmem_we;
		logic             dmem_re;
		logic [5:0]       io_addr;
		logic [7:0]       io_wdata;
		logic             io_we;
		logic [4:0]       pop_dst;
	} core_t;

	core_t       r;
	core_t       next_r;
	logic [4:0]  ptr_lo;
	logic [4:0]  ptr_hi;
	logic [15:0] ptr_val;
	logic [15:0] ptr_inc;
	logic [15:0] ptr_dec;
	logic [7:0]  bit_mask;
	logic        take;
	logic        is_bit_op;
	logic [15:0] disp_ext;

	rot_if rot ();

	rotate_unit u_rot (
		.rp (rot)
	);

	always_comb begin
		case (ptr_sel)
			exec_pkg::ptr_x: ptr_lo = exec_pkg::PTR_X_LO;
			exec_pkg::ptr_y: ptr_lo = exec_pkg::PTR_Y_LO;
			default:         ptr_lo = exec_pkg::PTR_Z_LO;
		endcase
	end

	// High half of each pair sits one index above the low half
	assign ptr_hi   = {ptr_lo[4:1], 1'b1};
	assign ptr_val  = {r.regs[ptr_hi], r.regs[ptr_lo]};
	assign ptr_inc  = ptr_val + exec_pkg::STEP_ONE;
	assign ptr_dec  = ptr_val - exec_pkg::STEP_ONE;
	assign bit_mask = exec_pkg::BIT_ONE << bit_sel;
	// Displacement is unsigned: zero-extended, never sign-extended
	assign disp_ext = 16'(disp);

	assign ready     = (r.state == exec_pkg::s_idle);
	assign take      = ready && start;
	assign is_bit_op = (op == exec_pkg::op_io_bit_set) || (op == exec_pkg::op_io_bit_clear);
	// Read side of a bit operation runs in the accept cycle to fit two cycles
	assign io_re     = take && is_bit_op;
	assign io_addr   = io_re ? {1'b0, io_bit_addr} : r.io_addr;
	assign done      = (r.state == exec_pkg::s_second)
		|| (take && op == exec_pkg::op_rotate_up_via_carry);

	assign rot.operand  = r.regs[dest_reg];
	assign rot.carry_in = r.sreg[exec_pkg::FLAG_C];

	assign rf_rdata   = r.regs[rf_addr];
	assign sp         = r.sp;
	assign sreg       = r.sreg;
	assign dmem_addr  = r.dmem_addr;
	assign dmem_wdata = r.dmem_wdata;
	assign dmem_we    = r.dmem_we;
	assign dmem_re    = r.dmem_re;
	assign io_wdata   = r.io_wdata;
	assign io_we      = r.io_we;

	always_comb begin
		next_r = r;
		next_r.dmem_we = 1'b0;
		next_r.dmem_re = 1'b0;
		next_r.io_we   = 1'b0;
		case (r.state)
			exec_pkg::s_idle: begin
				if (start) begin
					next_r.dmem_wdata = r.regs[source_working_reg];
					case (op)
						exec_pkg::op_indirect_store: begin
							next_r.dmem_addr = ptr_val;
							next_r.dmem_we   = 1'b1;
							next_r.state     = exec_pkg::s_second;
						end
						exec_pkg::op_indirect_store_inc: begin
							next_r.dmem_addr    = ptr_val;
							next_r.dmem_we      = 1'b1;
							next_r.regs[ptr_lo] = ptr_inc[7:0];
							next_r.regs[ptr_hi] = ptr_inc[15:8];
							next_r.state        = exec_pkg::s_second;
						end
						exec_pkg::op_indirect_store_dec: begin
							next_r.dmem_addr    = ptr_dec;
							next_r.dmem_we      = 1'b1;
							next_r.regs[ptr_lo] = ptr_dec[7:0];
							next_r.regs[ptr_hi] = ptr_dec[15:8];
							next_r.state        = exec_pkg::s_second;
						end
						exec_pkg::op_displaced_store: begin
							next_r.dmem_addr = ptr_val + disp_ext;
							next_r.dmem_we   = 1'b1;
							next_r.state     = exec_pkg::s_second;
						end
						exec_pkg::op_push: begin
							// Stack grows down: write at top, then move below it
							next_r.dmem_addr = r.sp;
							next_r.dmem_we   = 1'b1;
							next_r.sp        = r.sp - exec_pkg::STEP_ONE;
							next_r.state     = exec_pkg::s_second;
						end
						exec_pkg::op_pop: begin
							next_r.dmem_addr = r.sp + exec_pkg::STEP_ONE;
							next_r.dmem_re   = 1'b1;
							next_r.sp        = r.sp + exec_pkg::STEP_ONE;
							next_r.pop_dst   = dest_reg;
							next_r.state     = exec_pkg::s_second;
						end
						// Read-modify-write keeps the other bits of the I/O register
						exec_pkg::op_io_bit_set: begin
							next_r.io_addr  = {1'b0, io_bit_addr};
							next_r.io_wdata = io_rdata | bit_mask;
							next_r.io_we    = 1'b1;
							next_r.state    = exec_pkg::s_second;
						end
						exec_pkg::op_io_bit_clear: begin
							next_r.io_addr  = {1'b0, io_bit_addr};
							next_r.io_wdata = io_rdata & ~bit_mask;
							next_r.io_we    = 1'b1;
							next_r.state    = exec_pkg::s_second;
						end
						// Finishes in the accept cycle, so no second state
						exec_pkg::op_rotate_up_via_carry: begin
							next_r.regs[dest_reg] = rot.result;
							next_r.sreg[exec_pkg::FLAG_C] = rot.carry_out;
							next_r.sreg[exec_pkg::FLAG_Z] = rot.zero;
							next_r.sreg[exec_pkg::FLAG_N] = rot.negative;
							next_r.sreg[exec_pkg::FLAG_V] = rot.overflow;
						end
						default: begin
							// Unlisted codes are dropped and the core stays ready
							next_r.state = exec_pkg::s_idle;
						end
					endcase
				end else if (rf_we) begin
					// Preload only while idle, so it cannot race an instruction
					next_r.regs[rf_addr] = rf_wdata;
				end
			end
			exec_pkg::s_second: begin
				// Pop data is taken at the end of the read-strobe cycle
				if (r.dmem_re) begin
					next_r.regs[r.pop_dst] = dmem_rdata;
				end
				next_r.state = exec_pkg::s_idle;
			end
			default: begin
				next_r.state = exec_pkg::s_idle;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			r    <= '0;
			r.sp <= SP_INIT;
		end else begin
			r <= next_r;
		end
	end
endmodule
`default_nettype wire

// ==== verification/exec_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module exec_mem_model (
	// Clock
	input  wire logic        mclk,
	// Data memory and I/O space
	input  wire logic [15:0] dmem_addr,
	input  wire logic [7:0]  dmem_wdata,
	input  wire logic        dmem_we,
	input  wire logic        dmem_re,
	output logic [7:0]       dmem_rdata,
	input  wire logic [5:0]  io_addr,
	input  wire logic [7:0]  io_wdata,
	input  wire logic        io_we,
	input  wire logic        io_re,
	output logic [7:0]       io_rdata
);
	// Only the low address byte is decoded
	logic [7:0] mem [256];
	logic [7:0] io  [64];
	initial for (int i = 0; i < 64; i++) io[i] = 8'h5a;
	// Unread buses show the inverse so a stale value never passes
	assign dmem_rdata = dmem_re ? mem[dmem_addr[7:0]] : ~mem[dmem_addr[7:0]];
	assign io_rdata   = io_re ? io[io_addr] : ~io[io_addr];
	always @(posedge mclk) begin
		if (dmem_we) mem[dmem_addr[7:0]] <= dmem_wdata;
		if (io_we) io[io_addr] <= io_wdata;
	end
endmodule
`default_nettype wire

// ==== verification/store_stack_bit_shift_exec_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module exec_chk (
	input wire logic          mclk,
	input wire logic          rst_b,
	input wire logic          start,
	input wire exec_pkg::op_t op,
	input wire logic          ready,
	input wire logic          done,
	input wire logic [15:0]   sp,
	input wire logic [7:0]    sreg,
	input wire logic [15:0]   dmem_addr,
	input wire logic          dmem_we,
	input wire logic          dmem_re,
	input wire logic [5:0]    io_addr,
	input wire logic          io_we,
	input wire logic          io_re
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic tk;
	logic two;
	assign tk  = start && ready;
	assign two = tk && op < exec_pkg::op_rotate_up_via_carry;
	property p_two; two |=> done && !ready ##1 ready; endproperty
	a_two: assert property (p_two) else $error("two-cycle timing");
	property p_we; dmem_we |=> !dmem_we; endproperty
	a_we: assert property (p_we) else $error("write strobe too long");
	property p_flag; two |=> $stable(sreg); endproperty
	a_flag: assert property (p_flag) else $error("flags moved");
	property p_noio; two && op < exec_pkg::op_io_bit_set |=> !io_we; endproperty
	a_noio: assert property (p_noio) else $error("store hit io");
	property p_push; tk && op == exec_pkg::op_push |=> dmem_we && dmem_addr == $past(sp)
		&& sp == $past(sp) - 16'h0001; endproperty
	a_push: assert property (p_push) else $error("push wrong");
	property p_pop; tk && op == exec_pkg::op_pop |=> dmem_re && sp == $past(sp) + 16'h0001
		&& dmem_addr == sp; endproperty
	a_pop: assert property (p_pop) else $error("pop wrong");
	property p_bit; tk && (op == exec_pkg::op_io_bit_set || op == exec_pkg::op_io_bit_clear)
		|-> io_re ##1 io_we && done && io_addr == $past(io_addr); endproperty
	a_bit: assert property (p_bit) else $error("bit op wrong");
	property p_rot; tk && op == exec_pkg::op_rotate_up_via_carry |-> done ##1 ready; endproperty
	a_rot: assert property (p_rot) else $error("rotate timing");
endmodule
bind store_stack_bit_shift_exec exec_chk u_exec_chk (.mclk, .rst_b, .start, .op, .ready, .done,
	.sp, .sreg, .dmem_addr, .dmem_we, .dmem_re, .io_addr, .io_we, .io_re);
`default_nettype wire

// ==== verification/store_stack_bit_shift_exec_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module store_stack_bit_shift_exec_tb;
	logic           mclk, rst_b, start, ready, done, rf_we, dmem_we, dmem_re, io_we, io_re;
	exec_pkg::op_t  op;
	exec_pkg::ptr_t ptr_sel;
	logic [4:0]     source_working_reg, dest_reg, rf_addr, io_bit_addr;
	logic [5:0]     disp, io_addr;
	logic [2:0]     bit_sel;
	logic [7:0]     rf_wdata, rf_rdata, sreg, dmem_wdata, dmem_rdata, io_wdata, io_rdata;
	logic [15:0]    sp, dmem_addr;
	int             error_cnt, check_count, cycles;
	store_stack_bit_shift_exec u_store_stack_bit_shift_exec (.mclk, .rst_b, .start, .op,
		.ptr_sel, .source_working_reg, .dest_reg, .disp, .io_bit_addr, .bit_sel, .ready, .done,
		.rf_we, .rf_addr, .rf_wdata, .rf_rdata, .sp, .sreg, .dmem_addr, .dmem_wdata, .dmem_we,
		.dmem_re, .dmem_rdata, .io_addr, .io_wdata, .io_we, .io_re, .io_rdata);
	exec_mem_model u_exec_mem_model (.mclk, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re,
		.dmem_rdata, .io_addr, .io_wdata, .io_we, .io_re, .io_rdata);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			error_cnt++;
		end
	endtask
	task automatic wr(input logic [4:0] r, input logic [7:0] v);
		@(posedge mclk);
		rf_we <= 1'b1;
		rf_addr <= r;
		rf_wdata <= v;
		@(posedge mclk);
		rf_we <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] r, input logic [7:0] e);
		@(posedge mclk);
		rf_addr <= r;
		#1 cmp(rf_rdata, e);
	endtask
	// One field serves both register roles and the bit number
	task automatic go(input exec_pkg::op_t o, input exec_pkg::ptr_t p, input logic [4:0] s,
		input logic [5:0] q);
		@(posedge mclk);
		start <= 1'b1;
		op <= o;
		ptr_sel <= p;
		source_working_reg <= s;
		dest_reg <= s;
		disp <= q;
		io_bit_addr <= q[4:0];
		bit_sel <= s[2:0];
		@(posedge mclk);
		start <= 1'b0;
		#1 cmp(ready, o == exec_pkg::op_rotate_up_via_carry);
		cmp(done, o != exec_pkg::op_rotate_up_via_carry);
	endtask
	task automatic t_post();
		wr(5'h1a, 8'hff);
		wr(5'h1b, 8'h00);
		wr(5'h05, 8'ha5);
		go(exec_pkg::op_indirect_store_inc, exec_pkg::ptr_x, 5'h05, 6'h00);
		rd(5'h1a, 8'h00);
		rd(5'h1b, 8'h01);
		cmp(u_exec_mem_model.mem[8'hff], 8'ha5);
		go(exec_pkg::op_indirect_store, exec_pkg::ptr_x, 5'h05, 6'h00);
		rd(5'h1a, 8'h00);
		cmp(u_exec_mem_model.mem[8'h00], 8'ha5);
		$display("post-increment store done");
	endtask
	task automatic t_pre();
		wr(5'h1c, 8'h00);
		wr(5'h1d, 8'h01);
		wr(5'h05, 8'h3c);
		go(exec_pkg::op_indirect_store_dec, exec_pkg::ptr_y, 5'h05, 6'h00);
		rd(5'h1c, 8'hff);
		rd(5'h1d, 8'h00);
		cmp(u_exec_mem_model.mem[8'hff], 8'h3c);
		wr(5'h1e, 8'h10);
		go(exec_pkg::op_displaced_store, exec_pkg::ptr_z, 5'h05, 6'h3f);
		rd(5'h1e, 8'h10);
		cmp(u_exec_mem_model.mem[8'h4f], 8'h3c);
		$display("pre-decrement and displaced store done");
	endtask
	task automatic t_stack();
		wr(5'h05, 8'h96);
		go(exec_pkg::op_push, exec_pkg::ptr_x, 5'h05, 6'h00);
		cmp(sp, 16'h00fe);
		go(exec_pkg::op_pop, exec_pkg::ptr_x, 5'h07, 6'h00);
		rd(5'h07, 8'h96);
		cmp(sp, 16'h00ff);
		$display("push and pop done");
	endtask
	task automatic t_bits();
		go(exec_pkg::op_io_bit_set, exec_pkg::ptr_x, 5'h00, 6'h05);
		go(exec_pkg::op_io_bit_clear, exec_pkg::ptr_x, 5'h01, 6'h06);
		@(posedge mclk);
		#1 cmp(u_exec_mem_model.io[5], 8'h5b);
		cmp(u_exec_mem_model.io[6], 8'h58);
		cmp(sreg, 8'h00);
		$display("io bit set and clear done");
	endtask
	task automatic t_rot();
		wr(5'h09, 8'h81);
		go(exec_pkg::op_rotate_up_via_carry, exec_pkg::ptr_x, 5'h09, 6'h00);
		cmp(sreg, 8'h09);
		go(exec_pkg::op_rotate_up_via_carry, exec_pkg::ptr_x, 5'h09, 6'h00);
		cmp(sreg, 8'h00);
		rd(5'h09, 8'h05);
		wr(5'h09, 8'h80);
		go(exec_pkg::op_rotate_up_via_carry, exec_pkg::ptr_x, 5'h09, 6'h00);
		cmp(sreg, 8'h0b);
		rd(5'h09, 8'h00);
		wr(5'h09, 8'h40);
		go(exec_pkg::op_rotate_up_via_carry, exec_pkg::ptr_x, 5'h09, 6'h00);
		cmp(sreg, 8'h0c);
		rd(5'h09, 8'h81);
		$display("rotate done");
	endtask
	task automatic t_reset();
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		#1 cmp(sp, exec_pkg::SP_RESET);
		cmp(sreg, 8'h00);
		cmp(ready, 1'b1);
		cmp(rf_rdata, 8'h00);
		$display("mid-run reset done");
	endtask
	initial begin
		{rst_b, start, rf_we, source_working_reg, dest_reg, rf_addr, io_bit_addr} = '0;
		{disp, bit_sel, rf_wdata} = '0;
		op = exec_pkg::op_indirect_store;
		ptr_sel = exec_pkg::ptr_x;
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		t_post();
		t_pre();
		t_stack();
		t_bits();
		t_rot();
		t_reset();
		wrap_up();
	end
endmodule
`default_nettype wire
